// >>> design/ncrb_node_config.sv
`timescale 1ns/1ps
`include "ncrb_params.svh"

module ncrb_node_config
    import ncrb_pkg::*;
#(
    parameter int SLOTS = 16
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Register port
    input  wire ncrb_req_t     req,
    input  wire logic          reqValid,
    output      logic [7:0]    rdata,
    // Node context
    input  wire logic          isSubordinate,
    input  wire logic          applyNewStructure,
    input  wire logic          densityInput0Enable,
    input  wire logic          densityInput1Enable,
    input  wire logic          frameSyncTick,
    input  wire logic          sustainActive,
    input  wire logic          bitClockIn,
    input  wire logic [4:0]    localDownstreamSlotCount,
    // Clock output
    output      logic          secondClockOutput,
    // Monitor mode
    output      logic          monitorModeEnable,
    output      logic          monitorReceiverEnable,
    output      logic          monitorNoDiscovery,
    output      logic          monitorTerminationEnable,
    // Sustain
    output      logic          sustainEnable,
    output      logic [7:0]    sustainPinOut,
    output      logic [7:0]    sustainPinOen_n,
    // Density inputs
    output      logic [1:0]    highpassCornerSelect,
    output      logic          densityClockOnPin7,
    output      logic          densityClockPin7Oen_n,
    output      logic          bitClockOut,
    output      logic          bitClockFromSerialCfg,
    output      logic          in1FallFirst,
    output      logic          in0FallFirst,
    output      logic          routeToBus,
    output      logic          routeToLocal,
    // Upstream slots
    output      logic [SLOTS-1:0] upstreamSlotReceive,
    output      logic [5:0]    upstreamFirstSerialSlot
);

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    ncrb_clk2_t    clk2_ff;
    ncrb_monitor_t monitor_ff;
    ncrb_sustain_t sustain_ff;
    ncrb_density_t density_ff;
    logic [7:0]    upMask0_ff;
    logic [7:0]    upMask1_ff;
    logic [SLOTS-1:0] activeMask_ff;
    logic          wr;

    assign wr = reqValid & req.write;

    // Reserved bits dropped on write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clk2_ff    <= `NCRB_RST_VALUE;
            monitor_ff <= `NCRB_RST_VALUE;
            sustain_ff <= `NCRB_RST_VALUE;
            density_ff <= `NCRB_RST_VALUE;
            upMask0_ff <= `NCRB_RST_VALUE;
            upMask1_ff <= `NCRB_RST_VALUE;
        end else if (wr) begin
            unique case (req.addr)
                `NCRB_OFF_CLK2:     clk2_ff    <= req.wdata & `NCRB_MASK_CLK2;
                `NCRB_OFF_MONITOR:  monitor_ff <= req.wdata & `NCRB_MASK_MONITOR;
                `NCRB_OFF_SUSTAIN:  sustain_ff <= req.wdata & `NCRB_MASK_SUSTAIN;
                `NCRB_OFF_DENSITY2: density_ff <= req.wdata;
                `NCRB_OFF_UPMASK0:  upMask0_ff <= req.wdata;
                `NCRB_OFF_UPMASK1:  upMask1_ff <= req.wdata;
                default: ;
            endcase
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (reqValid && !req.write) begin
            unique case (req.addr)
                `NCRB_OFF_CLK2:     rdata <= clk2_ff;
                `NCRB_OFF_MONITOR:  rdata <= monitor_ff;
                `NCRB_OFF_SUSTAIN:  rdata <= sustain_ff;
                `NCRB_OFF_DENSITY2: rdata <= density_ff;
                `NCRB_OFF_UPMASK0:  rdata <= upMask0_ff;
                `NCRB_OFF_UPMASK1:  rdata <= upMask1_ff;
                default:            rdata <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Second clock output
    // ---------------------------------------------------------------
    // Runs from clk_sys, not a PLL
    ncrb_clk_divider u_clk2 (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .cfg     (clk2_ff),
        .clkOut  (secondClockOutput)
    );

    // ---------------------------------------------------------------
    // Monitor mode and sustain
    // ---------------------------------------------------------------
    // Mode bit gates every sub-field
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            monitorModeEnable        <= 1'b0;
            monitorReceiverEnable    <= 1'b0;
            monitorNoDiscovery       <= 1'b0;
            monitorTerminationEnable <= 1'b0;
        end else begin
            monitorModeEnable        <= monitor_ff.modeEnable;
            monitorReceiverEnable    <= monitor_ff.modeEnable & monitor_ff.receiverEnable;
            monitorNoDiscovery       <= monitor_ff.modeEnable & monitor_ff.noDiscovery;
            monitorTerminationEnable <= monitor_ff.modeEnable & ~monitor_ff.terminationDisable;
        end
    end

    logic sustainOn;
    assign sustainOn = isSubordinate & ~sustain_ff.disable_;

    // Pin drivers, one per general-purpose pin
    // At most one pin enabled, so no clash
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sus
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    sustainPinOut[gi]   <= 1'b0;
                    sustainPinOen_n[gi] <= 1'b1;
                end else begin
                    sustainPinOen_n[gi] <= ~(sustainOn & sustain_ff.outputEnable &
                                             (sustain_ff.pinSelect == 3'(gi)));
                    sustainPinOut[gi]   <= sustainActive;
                end
            end
        end
    endgenerate

    // Main node has no sustain
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sustainEnable <= 1'b0;
        end else begin
            sustainEnable <= sustainOn;
        end
    end

    // ---------------------------------------------------------------
    // Density clock at 64x frame sync
    // ---------------------------------------------------------------
    // Frame period is measured in system clocks; the pin toggles 128 times per frame.
    logic altActive;
    assign altActive = density_ff.altClock & (densityInput0Enable | densityInput1Enable);

    logic [15:0] periodCnt_ff;
    logic [15:0] period_ff;
    logic [15:0] phaseAcc_ff;
    logic        densClk_ff;
    logic [15:0] phaseSum;

    // Period between last two sync pulses
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            periodCnt_ff <= 16'h0000;
            period_ff    <= 16'h0000;
        end else if (frameSyncTick) begin
            periodCnt_ff <= 16'h0001;
            period_ff    <= periodCnt_ff;
        end else begin
            periodCnt_ff <= periodCnt_ff + 16'h0001;
        end
    end

    // Fractional accumulator avoids drift when the frame is not a multiple of 128
    assign phaseSum = phaseAcc_ff + 16'(2 * `NCRB_DENSITY_RATIO);

    // Phase restarts at each sync
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phaseAcc_ff <= 16'h0000;
            densClk_ff  <= 1'b0;
        end else if (!altActive || frameSyncTick) begin
            phaseAcc_ff <= 16'h0000;
            densClk_ff  <= 1'b0;
        end else if (phaseSum >= period_ff && period_ff != 16'h0000) begin
            phaseAcc_ff <= phaseSum - period_ff;
            densClk_ff  <= ~densClk_ff;
        end else begin
            phaseAcc_ff <= phaseSum;
        end
    end

    // Bit clock pin is asynchronous; two stages before use
    logic bitClkMeta_ff;
    logic bitClkSync_ff;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bitClkMeta_ff <= 1'b0;
            bitClkSync_ff <= 1'b0;
        end else begin
            bitClkMeta_ff <= bitClockIn;
            bitClkSync_ff <= bitClkMeta_ff;
        end
    end

    // Pin 7 and bit clock outputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            densityClockOnPin7    <= 1'b0;
            densityClockPin7Oen_n <= 1'b1;
            bitClockOut           <= 1'b0;
            bitClockFromSerialCfg <= 1'b0;
        end else begin
            densityClockOnPin7    <= densClk_ff;
            densityClockPin7Oen_n <= ~altActive;
            bitClockFromSerialCfg <= altActive & ~(isSubordinate & density_ff.invertedAltClock);
            if (altActive && isSubordinate && density_ff.invertedAltClock) begin
                bitClockOut <= ~densClk_ff;
            end else begin
                bitClockOut <= bitClkSync_ff;
            end
        end
    end

    // ---------------------------------------------------------------
    // Demodulation settings
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            highpassCornerSelect <= 2'h0;
            in1FallFirst         <= 1'b0;
            in0FallFirst         <= 1'b0;
            routeToBus           <= 1'b1;
            routeToLocal         <= 1'b0;
        end else begin
            highpassCornerSelect <= density_ff.highpassCorner;
            in1FallFirst         <= density_ff.in1FallFirst;
            in0FallFirst         <= density_ff.in0FallFirst;
            // Reserved route code keeps the default bus path
            unique case (density_ff.route)
                NCRB_ROUTE_BUS: begin
                    routeToBus   <= 1'b1;
                    routeToLocal <= 1'b0;
                end
                NCRB_ROUTE_LOCAL: begin
                    routeToBus   <= 1'b0;
                    routeToLocal <= 1'b1;
                end
                NCRB_ROUTE_BOTH: begin
                    routeToBus   <= 1'b1;
                    routeToLocal <= 1'b1;
                end
                NCRB_ROUTE_RSVD: begin
                    routeToBus   <= 1'b1;
                    routeToLocal <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Upstream receive masks, applied only on new structure
    // ---------------------------------------------------------------
    // Waits for the apply strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            activeMask_ff <= '0;
        end else if (applyNewStructure) begin
            activeMask_ff <= SLOTS'({upMask1_ff, upMask0_ff});
        end
    end

    // Main node takes no upstream slots
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            upstreamSlotReceive     <= '0;
            upstreamFirstSerialSlot <= 6'h00;
        end else begin
            upstreamSlotReceive     <= isSubordinate ? activeMask_ff : '0;
            upstreamFirstSerialSlot <= {1'b0, localDownstreamSlotCount};
        end
    end

endmodule : ncrb_node_config

// >>> design/ncrb_params.svh
`ifndef NCRB_PARAMS_SVH
`define NCRB_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define NCRB_OFF_CLK2      8'h5A
`define NCRB_OFF_MONITOR   8'h5B
`define NCRB_OFF_SUSTAIN   8'h5C
`define NCRB_OFF_DENSITY2  8'h5D
`define NCRB_OFF_UPMASK0   8'h60
`define NCRB_OFF_UPMASK1   8'h61

// ---------------------------------------------------------------
// Reset values and reserved-bit masks
// ---------------------------------------------------------------
`define NCRB_RST_VALUE     8'h00
`define NCRB_MASK_CLK2     8'hEF
`define NCRB_MASK_MONITOR  8'h0F
`define NCRB_MASK_SUSTAIN  8'h37

// ---------------------------------------------------------------
// Field positions and divide ratios
// ---------------------------------------------------------------
`define NCRB_CLK2_EN_BIT    7
`define NCRB_CLK2_INV_BIT   6
`define NCRB_CLK2_PDIV_BIT  5
`define NCRB_PDIV_SMALL     6'd2
`define NCRB_PDIV_LARGE     6'd32
`define NCRB_DENSITY_RATIO  64

`endif

// >>> design/ncrb_pkg.sv
package ncrb_pkg;

    typedef enum logic [1:0] {
        NCRB_ROUTE_BUS,
        NCRB_ROUTE_LOCAL,
        NCRB_ROUTE_BOTH,
        NCRB_ROUTE_RSVD
    } ncrb_route_t;

    typedef struct packed {
        logic       enable;
        logic       invert;
        logic       predivide;
        logic       spare;
        logic [3:0] divider;
    } ncrb_clk2_t;

    typedef struct packed {
        logic [3:0] spare;
        logic       terminationDisable;
        logic       noDiscovery;
        logic       receiverEnable;
        logic       modeEnable;
    } ncrb_monitor_t;

    typedef struct packed {
        logic [1:0]  spare;
        logic        disable_;
        logic        outputEnable;
        logic        spare2;
        logic [2:0]  pinSelect;
    } ncrb_sustain_t;

    typedef struct packed {
        logic [1:0]  highpassCorner;
        logic        invertedAltClock;
        logic        altClock;
        logic        in1FallFirst;
        logic        in0FallFirst;
        ncrb_route_t route;
    } ncrb_density_t;

    typedef struct packed {
        logic        write;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } ncrb_req_t;

endpackage : ncrb_pkg

// >>> design/ncrb_clk_divider.sv
`timescale 1ns/1ps
`include "ncrb_params.svh"

module ncrb_clk_divider
    import ncrb_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Settings
    input  wire ncrb_clk2_t cfg,
    // Clock out
    output      logic       clkOut
);

    logic [4:0] preCnt_ff;
    logic       preTick;
    logic [3:0] divCnt_ff;
    logic       level_ff;
    logic [4:0] preLimit;

    // ---------------------------------------------------------------
    // Pre-divide by 2 or 32, then by 2*(div+1)
    // ---------------------------------------------------------------
    assign preLimit = cfg.predivide ? 5'(`NCRB_PDIV_LARGE - 6'd1) : 5'(`NCRB_PDIV_SMALL - 6'd1);
    assign preTick  = (preCnt_ff >= preLimit);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            preCnt_ff <= 5'h00;
        end else if (!cfg.enable || preTick) begin
            preCnt_ff <= 5'h00;
        end else begin
            preCnt_ff <= preCnt_ff + 5'h01;
        end
    end

    // Half period is div+1 predivided ticks
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            divCnt_ff <= 4'h0;
            level_ff  <= 1'b0;
        end else if (!cfg.enable) begin
            divCnt_ff <= 4'h0;
            level_ff  <= 1'b0;
        end else if (preTick) begin
            if (divCnt_ff >= cfg.divider) begin
                divCnt_ff <= 4'h0;
                level_ff  <= ~level_ff;
            end else begin
                divCnt_ff <= divCnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clkOut <= 1'b0;
        end else begin
            clkOut <= cfg.enable & (level_ff ^ cfg.invert);
        end
    end

endmodule : ncrb_clk_divider

// >>> verif/ncrb_node_config_props.sv
`timescale 1ns/1ps
module ncrb_node_config_props
    import ncrb_pkg::*;
#(
    parameter int SLOTS = 16
) (
    // Clock, reset and inputs
    input wire logic             clk_sys,
    input wire logic             rstn,
    input wire ncrb_req_t        req,
    input wire logic             reqValid,
    input wire logic             isSubordinate,
    input wire logic             applyNewStructure,
    input wire logic             densityInput0Enable,
    input wire logic             densityInput1Enable,
    // Watched outputs
    input wire logic             secondClockOutput,
    input wire logic             monitorModeEnable,
    input wire logic             monitorReceiverEnable,
    input wire logic             monitorNoDiscovery,
    input wire logic             monitorTerminationEnable,
    input wire logic             sustainEnable,
    input wire logic [7:0]       sustainPinOen_n,
    input wire logic [1:0]       highpassCornerSelect,
    input wire logic             densityClockPin7Oen_n,
    input wire logic             routeToBus,
    input wire logic             routeToLocal,
    input wire logic [SLOTS-1:0] upstreamSlotReceive
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence wrTo(logic [7:0] a);
        reqValid && req.write && req.addr == a;
    endsequence
    // ----------------------------------------
    // Written fields show two edges later
    // ----------------------------------------
    AST_MON_MODE: assert property (wrTo(8'h5B) |=> ##1 monitorModeEnable == $past(req.wdata[0], 2))
        else $error("monitor mode bit not applied");
    AST_MON_RX: assert property (wrTo(8'h5B) |=> ##1 monitorReceiverEnable == ($past(req.wdata[0], 2) && $past(req.wdata[1], 2)))
        else $error("monitor receiver enable wrong");
    AST_MON_NDSC: assert property (wrTo(8'h5B) |=> ##1 monitorNoDiscovery == ($past(req.wdata[0], 2) && $past(req.wdata[2], 2)))
        else $error("monitor no-discovery wrong");
    AST_MON_TERM: assert property (wrTo(8'h5B) |=> ##1 monitorTerminationEnable == ($past(req.wdata[0], 2) && !$past(req.wdata[3], 2)))
        else $error("monitor termination wrong");
    // Subordinate held steady so only the write can move these
    AST_SUS_DIS: assert property (wrTo(8'h5C) ##0 isSubordinate [*3] |-> sustainEnable == !$past(req.wdata[5], 2))
        else $error("sustain enable wrong");
    AST_SUS_PIN: assert property (wrTo(8'h5C) ##0 isSubordinate [*3] |-> sustainPinOen_n == (($past(req.wdata[5:4], 2) == 2'h1) ? 8'(~(8'h01 << $past(req.wdata[2:0], 2))) : 8'hFF))
        else $error("sustain pin enable wrong");
    AST_HPF: assert property (wrTo(8'h5D) |=> ##1 highpassCornerSelect == $past(req.wdata[7:6], 2))
        else $error("highpass corner wrong");
    AST_ROUTE: assert property (wrTo(8'h5D) |=> ##1 routeToBus == ($past(req.wdata[1:0], 2) != 2'h1) && routeToLocal == ($past(req.wdata[1:0], 2) inside {2'h1, 2'h2}))
        else $error("density route wrong");
    AST_MASK_HOLD: assert property (isSubordinate [*4] ##0 $changed(upstreamSlotReceive) |-> $past(applyNewStructure, 2))
        else $error("slot mask moved without apply");
    AST_ALT_IGNORED: assert property (!$past(densityInput0Enable) && !$past(densityInput1Enable) && !$past(densityInput0Enable, 2) && !$past(densityInput1Enable, 2) |-> densityClockPin7Oen_n)
        else $error("pin 7 driven with inputs off");
    COV_MASK: cover property (applyNewStructure ##2 upstreamSlotReceive != '0);
    COV_CLK2: cover property ($rose(secondClockOutput));
    COV_PIN7: cover property (!densityClockPin7Oen_n);
endmodule : ncrb_node_config_props

bind ncrb_node_config ncrb_node_config_props #(.SLOTS(SLOTS)) uProps (
    .clk_sys(clk_sys), .rstn(rstn), .req(req), .reqValid(reqValid), .isSubordinate(isSubordinate),
    .applyNewStructure(applyNewStructure), .densityInput0Enable(densityInput0Enable),
    .densityInput1Enable(densityInput1Enable), .secondClockOutput(secondClockOutput),
    .monitorModeEnable(monitorModeEnable), .monitorReceiverEnable(monitorReceiverEnable),
    .monitorNoDiscovery(monitorNoDiscovery), .monitorTerminationEnable(monitorTerminationEnable),
    .sustainEnable(sustainEnable), .sustainPinOen_n(sustainPinOen_n), .highpassCornerSelect(highpassCornerSelect),
    .densityClockPin7Oen_n(densityClockPin7Oen_n), .routeToBus(routeToBus), .routeToLocal(routeToLocal),
    .upstreamSlotReceive(upstreamSlotReceive)
);

// >>> verif/node_config_register_bank_tb.sv
`timescale 1ns/1ps
module node_config_register_bank_tb
    import ncrb_pkg::*;
;
    logic        clk_sys, rstn, reqValid, isSubordinate, applyNewStructure, sub, lastD, lastB;
    logic        densityInput0Enable, densityInput1Enable, frameSyncTick, sustainActive, bitClockIn;
    logic        secondClockOutput, monitorModeEnable, monitorReceiverEnable, monitorNoDiscovery;
    logic        monitorTerminationEnable, sustainEnable, densityClockOnPin7, densityClockPin7Oen_n;
    logic        bitClockOut, bitClockFromSerialCfg, in1FallFirst, in0FallFirst, routeToBus, routeToLocal;
    logic [4:0]  slotCount;
    logic [5:0]  upstreamFirstSerialSlot;
    logic [1:0]  highpassCornerSelect;
    logic [7:0]  rdata, sustainPinOut, sustainPinOen_n, fsCnt;
    logic [15:0] upstreamSlotReceive, act, nD, nB;
    logic [31:0] rnd;
    logic [7:0]  mdl [256];
    logic [7:0]  tbl [8] = '{8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h60, 8'h61, 8'h5F, 8'h7F};
    logic [7:0]  cfg2 [5] = '{8'h80, 8'h85, 8'h8F, 8'hA0, 8'hA3};
    ncrb_req_t   req;
    int          err_count, checks, i, k, p;

    ncrb_node_config #(.SLOTS(16)) DUT (
        .clk_sys(clk_sys), .rstn(rstn), .req(req), .reqValid(reqValid), .rdata(rdata),
        .isSubordinate(isSubordinate), .applyNewStructure(applyNewStructure),
        .densityInput0Enable(densityInput0Enable), .densityInput1Enable(densityInput1Enable),
        .frameSyncTick(frameSyncTick), .sustainActive(sustainActive), .bitClockIn(bitClockIn),
        .localDownstreamSlotCount(slotCount), .secondClockOutput(secondClockOutput),
        .monitorModeEnable(monitorModeEnable), .monitorReceiverEnable(monitorReceiverEnable),
        .monitorNoDiscovery(monitorNoDiscovery), .monitorTerminationEnable(monitorTerminationEnable),
        .sustainEnable(sustainEnable), .sustainPinOut(sustainPinOut), .sustainPinOen_n(sustainPinOen_n),
        .highpassCornerSelect(highpassCornerSelect), .densityClockOnPin7(densityClockOnPin7),
        .densityClockPin7Oen_n(densityClockPin7Oen_n), .bitClockOut(bitClockOut),
        .bitClockFromSerialCfg(bitClockFromSerialCfg), .in1FallFirst(in1FallFirst), .in0FallFirst(in0FallFirst),
        .routeToBus(routeToBus), .routeToLocal(routeToLocal), .upstreamSlotReceive(upstreamSlotReceive),
        .upstreamFirstSerialSlot(upstreamFirstSerialSlot)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Frame sync every 256 cycles, so 64x sync means a 4-cycle clock
    always @(posedge clk_sys) begin
        fsCnt <= fsCnt + 8'h01;
        frameSyncTick <= (fsCnt == 8'hFF);
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h5A: return 8'hEF;
            8'h5B: return 8'h0F;
            8'h5C: return 8'h37;
            8'h5D, 8'h60, 8'h61: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction : msk

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic complete_run;
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // Unmapped places are modelled with an all-zero mask: writes lost, reads 00
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{w, a, d};
        reqValid <= 1'b1;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        #1;
        if (w) mdl[a] = d & msk(a);
        else chk("rdata", {8'h00, rdata}, {8'h00, mdl[a]});
    endtask : acc

    task automatic chkOut;
        logic [7:0] m, s, d;
        m = mdl[8'h5B];
        s = mdl[8'h5C];
        s[4] = s[4] & ~s[5];
        d = mdl[8'h5D];
        chk("monitorModeEnable", monitorModeEnable, m[0]);
        chk("monitorReceiverEnable", monitorReceiverEnable, m[0] & m[1]);
        chk("monitorNoDiscovery", monitorNoDiscovery, m[0] & m[2]);
        chk("monitorTerminationEnable", monitorTerminationEnable, m[0] & ~m[3]);
        chk("sustainEnable", sustainEnable, isSubordinate & ~s[5]);
        chk("sustainPinOen_n", sustainPinOen_n, (isSubordinate & s[4]) ? 8'(~(8'h01 << s[2:0])) : 8'hFF);
        if (isSubordinate & s[4]) chk("sustainPinOut", sustainPinOut[s[2:0]], sustainActive);
        chk("highpassCornerSelect", highpassCornerSelect, d[7:6]);
        chk("in1FallFirst", in1FallFirst, d[3]);
        chk("in0FallFirst", in0FallFirst, d[2]);
        chk("routeToBus", routeToBus, d[1:0] != 2'h1);
        chk("routeToLocal", routeToLocal, d[1:0] == 2'h1 || d[1:0] == 2'h2);
        chk("upstreamSlotReceive", upstreamSlotReceive, isSubordinate ? act : 16'h0000);
        chk("upstreamFirstSerialSlot", {10'h000, upstreamFirstSerialSlot}, {11'h000, slotCount});
        chk("densityClockPin7Oen_n", densityClockPin7Oen_n, 1'b1);
        chk("bitClockOut", bitClockOut, bitClockIn);
    endtask : chkOut

    task automatic doReset;
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (mdl[j]) mdl[j] = 8'h00;
        act = 16'h0000;
        repeat (3) @(posedge clk_sys);
        #1;
        chkOut();
        foreach (tbl[j]) acc(1'b0, tbl[j], 8'h00);
    endtask : doReset

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        complete_run();
    end

    initial begin
        {rstn, reqValid, applyNewStructure, densityInput0Enable, densityInput1Enable} = '0;
        {isSubordinate, sustainActive, bitClockIn, slotCount, fsCnt, frameSyncTick} = '0;
        req = '0;
        rnd = 32'hAC92D576;
        doReset();
        // Random traffic; mask apply only while subordinate
        for (i = 0; i < 48; i++) begin
            rnd = lfsr(rnd);
            sub = rnd[8] | rnd[9];
            @(posedge clk_sys);
            isSubordinate <= sub;
            sustainActive <= rnd[10];
            bitClockIn <= rnd[11];
            slotCount <= rnd[16:12];
            acc(1'b1, tbl[rnd[2:0]], rnd[31:24]);
            if (rnd[17] && sub) begin
                @(posedge clk_sys);
                applyNewStructure <= 1'b1;
                @(posedge clk_sys);
                applyNewStructure <= 1'b0;
                act = {mdl[8'h61], mdl[8'h60]};
            end
            acc(1'b0, tbl[rnd[2:0]], 8'h00);
            repeat (2) @(posedge clk_sys);
            #1;
            chkOut();
        end
        // Alternate density clock with inverted copy on the bit clock
        @(posedge clk_sys);
        isSubordinate <= 1'b1;
        acc(1'b1, 8'h5D, 8'h30);
        repeat (600) @(posedge clk_sys);
        #1;
        chk("densityClockPin7Oen_n", densityClockPin7Oen_n, 1'b1);
        @(posedge clk_sys);
        densityInput1Enable <= 1'b1;
        repeat (800) @(posedge clk_sys);
        #1;
        {nD, nB, lastD, lastB} = {32'h0, densityClockOnPin7, bitClockOut};
        for (k = 0; k < 256; k++) begin
            @(posedge clk_sys);
            #1;
            if (densityClockOnPin7 && !lastD) nD++;
            if (bitClockOut && !lastB) nB++;
            {lastD, lastB} = {densityClockOnPin7, bitClockOut};
        end
        chk("densityClockRises", nD, 16'h0040);
        chk("bitClockRises", nB, 16'h0040);
        chk("densityClockPin7Oen_n", densityClockPin7Oen_n, 1'b0);
        chk("bitClockFromSerialCfg", bitClockFromSerialCfg, 1'b0);
        acc(1'b1, 8'h5D, 8'h10);
        @(posedge clk_sys);
        #1;
        chk("bitClockFromSerialCfg", bitClockFromSerialCfg, 1'b1);
        @(posedge clk_sys);
        densityInput1Enable <= 1'b0;
        doReset();
        // Second clock: period counted between two later rising edges
        foreach (cfg2[j]) begin
            acc(1'b1, 8'h5A, cfg2[j]);
            {p, k, lastD} = {32'h0, 32'h0, 1'b1};
            for (i = 0; i < 4000 && k < 3; i++) begin
                @(posedge clk_sys);
                #1;
                if (k == 2) p++;
                if (secondClockOutput && !lastD) k++;
                lastD = secondClockOutput;
            end
            chk("secondClockPeriod", p[15:0], 16'((cfg2[j][5] ? 32 : 2) * 2 * (cfg2[j][3:0] + 1)));
        end
        complete_run();
    end
endmodule : node_config_register_bank_tb
